// ===== usb_packet_buffer.sv
// Functional notes
// - OUT byte not stored before next arrives: drop it, stop writing, no ack, overrun flag.
// - IN byte not fetched in time: stop reading, signal stuff error, overrun flag.
// - After resume, allow full 3 ms for first SOF with no suspend interrupt.
// - Suspend mask bit set blocks suspend interrupt; clearing it re-enables it.
// - Store packet from rx start, payload plus two CRC bytes, capped at allocation.
// - CRC low byte goes to first trailing location, high byte to second.
// - CRC16 checked in own logic, independent of bytes copied to memory.
// - Endpoint 0xF answered for every 7-bit device address, 0x60 to 0x6F included.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module usb_packet_buffer
  import usb_pkt_pkg::*;
#(
  parameter int SOF_WAIT_CYC = usb_pkt_pkg::SOF_WAIT_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [usb_pkt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [usb_pkt_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [usb_pkt_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [usb_pkt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [usb_pkt_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tok_valid,
  input wire logic tok_in,
  input wire logic [usb_pkt_pkg::DADDR_W-1:0] tok_addr,
  input wire logic [usb_pkt_pkg::EP_W-1:0] tok_endp,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  output logic hs_ack,
  input wire logic tx_byte_req,
  output logic [7:0] tx_byte,
  output logic tx_byte_ready,
  output logic tx_eop,
  output logic tx_stuff_err,
  input wire logic link_sof,
  input wire logic link_suspend,
  output logic resume_req,
  output logic irq
);
  localparam int WIN_W = $clog2(SOF_WAIT_CYC + 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(SOF_WAIT_CYC - 1);

  logic rst_meta_ff, rst_sync_ff;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Register bus: write side
  logic aw_got_ff, w_got_ff, bvalid_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [DATA_W-1:0] w_data_ff;
  logic [STRB_W-1:0] w_strb_ff;
  logic [1:0] bresp_ff;
  logic rd_stage_ff, rvalid_ff;
  logic [ADDR_W-1:0] ar_addr_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = a[MEM_SEL_BIT] || a == REG_CTRL || a == REG_STATUS || a == REG_MASK
      || a == REG_DADDR || a == REG_RXCFG || a == REG_TXCFG || a == REG_RXSTAT;
  endfunction

  wire do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire [DATA_W-1:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}},
    {8{w_strb_ff[0]}}};
  wire [DATA_W-1:0] wr_bits = w_data_ff & wmask;
  wire wr_mem = aw_addr_ff[MEM_SEL_BIT];
  wire wr_ctrl = do_wr && aw_addr_ff == REG_CTRL;
  wire wr_status = do_wr && aw_addr_ff == REG_STATUS;
  wire wr_mask = do_wr && aw_addr_ff == REG_MASK;
  wire wr_daddr = do_wr && aw_addr_ff == REG_DADDR;
  wire wr_rxcfg = do_wr && aw_addr_ff == REG_RXCFG;
  wire wr_txcfg = do_wr && aw_addr_ff == REG_TXCFG;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rd_stage_ff && !rvalid_ff && !do_wr;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge ref_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bresp_ff <= RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= aw_hs || (aw_got_ff && !do_wr);
      w_got_ff <= w_hs || (w_got_ff && !do_wr);
      if (aw_hs)
        aw_addr_ff <= s_axi_awaddr;
      if (w_hs)
      begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_wr)
        bresp_ff <= addr_known(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      bvalid_ff <= do_wr || (bvalid_ff && !s_axi_bready);
    end
  end

  // Control registers
  logic [ST_W-1:0] status_ff, mask_ff, ev_set;
  logic [DADDR_W-1:0] daddr_ff;
  logic [DATA_W-1:0] rxcfg_ff, txcfg_ff;
  logic resume_ff;
  wire [ST_W-1:0] st_clr = wr_status ? wr_bits[ST_W-1:0] : '0;

  always_ff @(posedge ref_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      status_ff <= '0;
      mask_ff <= '0;
      daddr_ff <= '0;
      rxcfg_ff <= '0;
      txcfg_ff <= '0;
      resume_ff <= 1'b0;
    end
    else
    begin
      status_ff <= (status_ff & ~st_clr) | ev_set;
      if (wr_mask)
        mask_ff <= (mask_ff & ~wmask[ST_W-1:0]) | wr_bits[ST_W-1:0];
      if (wr_daddr)
        daddr_ff <= (daddr_ff & ~wmask[DADDR_W-1:0]) | wr_bits[DADDR_W-1:0];
      if (wr_rxcfg)
        rxcfg_ff <= ((rxcfg_ff & ~wmask) | wr_bits) & RXCFG_RMASK;
      if (wr_txcfg)
        txcfg_ff <= ((txcfg_ff & ~wmask) | wr_bits) & TXCFG_RMASK;
      resume_ff <= wr_ctrl && wr_bits[CTRL_RESUME];
    end
  end

  assign irq = |(status_ff & ~mask_ff);
  assign resume_req = resume_ff;

  // Receive path
  logic rx_armed_ff, rx_abort_ff, wr_pend_ff, crc_ok_ff, hs_ack_ff;
  logic [MEM_AW-1:0] rx_addr_ff, pend_addr_ff;
  logic [7:0] pend_data_ff;
  logic [CNT_W-1:0] rx_cnt_ff;
  logic [15:0] crc_ff;
  logic [EP_W-1:0] rx_ep_ff;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    crc_step = r;
  endfunction

  wire [MEM_AW-1:0] rx_start = rxcfg_ff[MEM_AW-1:0];
  wire [NB_W-1:0] rx_nblk = rxcfg_ff[RXCFG_NB_LSB +: NB_W];
  wire [CNT_W-1:0] rx_alloc = rxcfg_ff[RXCFG_BSZ] ? (CNT_W'(rx_nblk) << BLK_LARGE_SH)
    : (CNT_W'(rx_nblk) << BLK_SMALL_SH);
  wire tok_match = tok_valid && tok_addr == daddr_ff;
  wire rx_take = rx_byte_valid && rx_armed_ff && !rx_abort_ff;
  wire rx_ovr = rx_take && wr_pend_ff;
  wire rx_room = rx_cnt_ff < rx_alloc;
  wire rx_store = rx_take && !wr_pend_ff && rx_room;
  wire crc_good = crc_ff == CRC_RESID;
  wire rx_close = rx_end && rx_armed_ff;

  // Memory port arbitration: bus first, then receive, then transmit prefetch
  logic tx_active_ff, tx_have_ff, tx_rd_ff, tx_err_ff;
  logic [MEM_AW-1:0] tx_ptr_ff;
  logic [CNT_W-1:0] tx_left_ff;
  logic [7:0] tx_byte_ff, mem_rdata;
  wire axi_mem_wr = do_wr && wr_mem;
  wire axi_mem_rd = ar_hs && s_axi_araddr[MEM_SEL_BIT];
  wire rx_fire = wr_pend_ff && !axi_mem_wr && !axi_mem_rd;
  wire tx_need = tx_active_ff && !tx_have_ff && !tx_rd_ff && tx_left_ff != '0
    && !tx_byte_req;
  wire tx_fire = tx_need && !axi_mem_wr && !axi_mem_rd && !rx_fire;
  wire mem_we = axi_mem_wr || rx_fire;
  wire [MEM_AW-1:0] mem_addr = axi_mem_wr ? aw_addr_ff[MEM_SEL_BIT-1 -: MEM_AW]
    : axi_mem_rd ? s_axi_araddr[MEM_SEL_BIT-1 -: MEM_AW]
    : rx_fire ? pend_addr_ff : tx_ptr_ff;
  wire [7:0] mem_wdata = axi_mem_wr ? w_data_ff[7:0] : pend_data_ff;

  pkt_ram u_ram (
    .clk(ref_clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_ff(mem_rdata)
  );

  always_ff @(posedge ref_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      rx_armed_ff <= 1'b0;
      rx_abort_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      rx_addr_ff <= '0;
      pend_addr_ff <= '0;
      pend_data_ff <= '0;
      rx_cnt_ff <= '0;
      crc_ff <= CRC_INIT;
      rx_ep_ff <= '0;
      crc_ok_ff <= 1'b0;
      hs_ack_ff <= 1'b0;
    end
    else
    begin
      hs_ack_ff <= rx_close && !rx_abort_ff && crc_good;
      if (tok_valid)
      begin
        rx_armed_ff <= tok_match && !tok_in;
        rx_abort_ff <= 1'b0;
        rx_cnt_ff <= '0;
        rx_addr_ff <= rx_start;
        crc_ff <= CRC_INIT;
        rx_ep_ff <= tok_endp;
      end
      else if (rx_close)
      begin
        rx_armed_ff <= 1'b0;
        crc_ok_ff <= crc_good;
      end
      else
      begin
        if (rx_byte_valid && rx_armed_ff)
          crc_ff <= crc_step(crc_ff, rx_byte);
        if (rx_ovr)
          rx_abort_ff <= 1'b1;
        if (rx_store)
        begin
          rx_addr_ff <= rx_addr_ff + 1'b1;
          rx_cnt_ff <= rx_cnt_ff + 1'b1;
          pend_addr_ff <= rx_addr_ff;
          pend_data_ff <= rx_byte;
        end
      end
      wr_pend_ff <= (wr_pend_ff && !rx_fire) || rx_store;
    end
  end

  assign hs_ack = hs_ack_ff;

  // Transmit path
  wire tx_underrun = tx_byte_req && tx_active_ff && !tx_have_ff
    && (tx_left_ff != '0 || tx_rd_ff);
  wire tx_finish = tx_byte_req && tx_eop;

  always_ff @(posedge ref_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      tx_active_ff <= 1'b0;
      tx_have_ff <= 1'b0;
      tx_rd_ff <= 1'b0;
      tx_err_ff <= 1'b0;
      tx_ptr_ff <= '0;
      tx_left_ff <= '0;
      tx_byte_ff <= '0;
    end
    else
    begin
      tx_err_ff <= tx_underrun;
      tx_rd_ff <= tx_fire;
      if (tok_valid)
      begin
        tx_active_ff <= tok_match && tok_in;
        tx_have_ff <= 1'b0;
        tx_ptr_ff <= txcfg_ff[MEM_AW-1:0];
        tx_left_ff <= txcfg_ff[TXCFG_CNT_LSB +: CNT_W];
      end
      else if (tx_underrun || tx_finish)
      begin
        tx_active_ff <= 1'b0;
        tx_have_ff <= 1'b0;
      end
      else
      begin
        if (tx_fire)
        begin
          tx_ptr_ff <= tx_ptr_ff + 1'b1;
          tx_left_ff <= tx_left_ff - 1'b1;
        end
        if (tx_rd_ff)
        begin
          tx_have_ff <= 1'b1;
          tx_byte_ff <= mem_rdata;
        end
        else if (tx_byte_req && tx_have_ff)
          tx_have_ff <= 1'b0;
      end
    end
  end

  assign tx_byte = tx_byte_ff;
  assign tx_byte_ready = tx_have_ff;
  assign tx_eop = tx_active_ff && !tx_have_ff && !tx_rd_ff && tx_left_ff == '0;
  assign tx_stuff_err = tx_err_ff;

  // Frame start window after resume
  logic win_ff;
  logic [WIN_W-1:0] win_cnt_ff;
  wire win_expire = win_ff && !link_sof && win_cnt_ff == WIN_LAST;
  wire suspend_interrupt_ev = link_suspend && !win_ff && !resume_ff;

  always_ff @(posedge ref_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      win_ff <= 1'b0;
      win_cnt_ff <= '0;
    end
    else if (resume_ff)
    begin
      win_ff <= 1'b1;
      win_cnt_ff <= '0;
    end
    else if (win_ff)
    begin
      win_ff <= !(link_sof || win_expire);
      win_cnt_ff <= win_cnt_ff + 1'b1;
    end
  end

  always_comb
  begin
    ev_set = '0;
    ev_set[ST_OVR] = rx_ovr || tx_underrun;
    ev_set[ST_SUSPEND_INTERRUPT] = suspend_interrupt_ev;
    ev_set[ST_RXDONE] = rx_close;
    ev_set[ST_TXDONE] = tx_finish;
    ev_set[ST_EXPECTED_FRAME_START_MISSED] = win_expire;
    ev_set[ST_CRCERR] = rx_close && !crc_good;
  end

  // Register bus: read side
  wire [DATA_W-1:0] rxstat_word = (DATA_W'(crc_ok_ff) << RXSTAT_OK_LSB)
    | (DATA_W'(rx_ep_ff) << RXSTAT_EP_LSB) | DATA_W'(rx_cnt_ff);
  wire [DATA_W-1:0] rd_mux = ar_addr_ff[MEM_SEL_BIT] ? DATA_W'(mem_rdata)
    : ar_addr_ff == REG_STATUS ? DATA_W'(status_ff)
    : ar_addr_ff == REG_MASK ? DATA_W'(mask_ff)
    : ar_addr_ff == REG_DADDR ? DATA_W'(daddr_ff)
    : ar_addr_ff == REG_RXCFG ? rxcfg_ff
    : ar_addr_ff == REG_TXCFG ? txcfg_ff
    : ar_addr_ff == REG_RXSTAT ? rxstat_word : '0;

  always_ff @(posedge ref_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      rd_stage_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      ar_addr_ff <= '0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      rd_stage_ff <= ar_hs;
      if (ar_hs)
        ar_addr_ff <= s_axi_araddr;
      if (rd_stage_ff)
      begin
        rdata_ff <= rd_mux;
        rresp_ff <= addr_known(ar_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      rvalid_ff <= rd_stage_ff || (rvalid_ff && !s_axi_rready);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_sync_ff);

  sequence late_byte_s;
    rx_byte_valid && rx_armed_ff && !rx_abort_ff && wr_pend_ff && !tok_valid && !rx_end;
  endsequence
  sequence starved_s;
    tx_byte_req && tx_active_ff && !tx_have_ff && tx_left_ff != '0 && !tok_valid;
  endsequence

  rx_overrun_flag_a: assert property (late_byte_s |=> status_ff[ST_OVR] && rx_abort_ff)
    else $error("overrun not flagged on late byte");
  rx_no_ack_a: assert property (rx_close && rx_abort_ff |=> !hs_ack)
    else $error("ack given after overrun");
  tx_underrun_a: assert property (starved_s |=> tx_stuff_err && !tx_active_ff && !tx_rd_ff
    ##1 !tx_rd_ff && !tx_byte_ready)
    else $error("underrun not reported or reading continued");
  resume_window_a: assert property (resume_ff ##1 (!link_sof && !link_suspend) [*2]
    |-> win_ff && !status_ff[ST_SUSPEND_INTERRUPT] || $past(status_ff[ST_SUSPEND_INTERRUPT], 2))
    else $error("frame start window not held after resume");
  window_suspend_interrupt_a: assert property (win_ff && link_suspend && !status_ff[ST_SUSPEND_INTERRUPT] && !wr_status
    |=> !status_ff[ST_SUSPEND_INTERRUPT])
    else $error("suspend raised inside frame start window");
  suspend_interrupt_mask_a: assert property (mask_ff[ST_SUSPEND_INTERRUPT] && !irq && ev_set == ST_W'(1 << ST_SUSPEND_INTERRUPT)
    && !wr_mask |=> !irq)
    else $error("masked suspend reached interrupt");
  suspend_interrupt_unmask_a: assert property (wr_mask && !wr_bits[ST_SUSPEND_INTERRUPT] && status_ff[ST_SUSPEND_INTERRUPT]
    && !wr_status |=> irq)
    else $error("unmasked suspend did not interrupt");
  rx_cap_a: assert property (rx_armed_ff |-> rx_cnt_ff <= rx_alloc || $changed(rxcfg_ff))
    else $error("receive wrote beyond allocation");
  rx_order_a: assert property (rx_store && !tok_valid |=> rx_addr_ff == $past(rx_addr_ff) + 1'b1
    && pend_data_ff == $past(rx_byte))
    else $error("received bytes stored out of order");
  crc_gate_a: assert property (rx_close && !crc_good |=> !hs_ack && status_ff[ST_CRCERR])
    else $error("bad crc accepted");
  any_addr_a: assert property (tok_valid && tok_addr == daddr_ff && !tok_in
    |=> rx_armed_ff && rx_ep_ff == $past(tok_endp))
    else $error("addressed token not accepted");
  ovr_sticky_a: assert property (status_ff[ST_OVR] && !(wr_status && wr_bits[ST_OVR])
    |=> status_ff[ST_OVR])
    else $error("overrun flag lost without clear");
endmodule

// ===== usb_pkt_pkg.sv
package usb_pkt_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int DADDR_W = 7;
  localparam int EP_W = 4;
  localparam int MEM_AW = 9;
  localparam int MEM_DEPTH = 512;
  localparam int MEM_SEL_BIT = 11;
  localparam int CNT_W = 10;
  localparam int NB_W = 5;

  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] REG_MASK = 12'h008;
  localparam logic [ADDR_W-1:0] REG_DADDR = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_RXCFG = 12'h010;
  localparam logic [ADDR_W-1:0] REG_TXCFG = 12'h014;
  localparam logic [ADDR_W-1:0] REG_RXSTAT = 12'h018;

  localparam int ST_OVR = 0;
  localparam int ST_SUSPEND_INTERRUPT = 1;
  localparam int ST_RXDONE = 2;
  localparam int ST_TXDONE = 3;
  localparam int ST_EXPECTED_FRAME_START_MISSED = 4;
  localparam int ST_CRCERR = 5;
  localparam int ST_W = 6;

  localparam int CTRL_RESUME = 0;
  localparam int RXCFG_BSZ = 15;
  localparam int RXCFG_NB_LSB = 16;
  localparam int TXCFG_CNT_LSB = 16;
  localparam int RXSTAT_EP_LSB = 16;
  localparam int RXSTAT_OK_LSB = 20;
  localparam logic [DATA_W-1:0] RXCFG_RMASK = 32'h001F_81FF;
  localparam logic [DATA_W-1:0] TXCFG_RMASK = 32'h03FF_01FF;
  localparam int BLK_SMALL_SH = 1;
  localparam int BLK_LARGE_SH = 5;

  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_RESID = 16'hB001;

  localparam int SOF_WAIT_MS = 3;
  localparam int CLK_KHZ = 250000;
  localparam int SOF_WAIT_CYCLES = SOF_WAIT_MS * CLK_KHZ;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== pkt_ram.sv
`timescale 1ns/1ps
module pkt_ram
  import usb_pkt_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [usb_pkt_pkg::MEM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_ff
);
  logic [7:0] mem_q [MEM_DEPTH];

  // Read-first single port, registered read data
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_q[addr] <= wdata;
    end
    rdata_ff <= mem_q[addr];
  end
endmodule

// ===== usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
  input wire logic ref_clk,
  output logic tok_valid,
  output logic tok_in,
  output logic [6:0] tok_addr,
  output logic [3:0] tok_endp,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_end,
  output logic tx_byte_req,
  output logic link_sof,
  output logic link_suspend
);
  initial
  begin
    {tok_valid, tok_in, tok_addr, tok_endp, rx_byte_valid, rx_byte, rx_end} = '0;
    {tx_byte_req, link_sof, link_suspend} = '0;
  end
  // Token pulse; address lines flip once released
  task token(input logic d, input logic [6:0] a, input logic [3:0] e);
    tok_in <= d;
    tok_addr <= a;
    tok_endp <= e;
    tok_valid <= 1'b1;
    @(posedge ref_clk);
    tok_valid <= 1'b0;
    tok_addr <= ~a;
    tok_endp <= ~e;
    @(posedge ref_clk);
  endtask
  // Bytes g cycles apart, then end of packet
  task packet(input logic [7:0] b[$], input int g);
    for (int i = 0; i < b.size(); i++)
    begin
      rx_byte <= b[i];
      rx_byte_valid <= 1'b1;
      @(posedge ref_clk);
      if (g > 1 || i == b.size() - 1)
      begin
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b[i];
        repeat (g - 1) @(posedge ref_clk);
      end
    end
    rx_end <= 1'b1;
    @(posedge ref_clk);
    rx_end <= 1'b0;
  endtask
  task req(input int n);
    tx_byte_req <= 1'b1;
    repeat (n) @(posedge ref_clk);
    tx_byte_req <= 1'b0;
  endtask
  task sof;
    link_sof <= 1'b1;
    @(posedge ref_clk);
    link_sof <= 1'b0;
  endtask
  task suspend_interrupt;
    link_suspend <= 1'b1;
    @(posedge ref_clk);
    link_suspend <= 1'b0;
  endtask
endmodule

// ===== tb_usb_packet_buffer.sv
`timescale 1ns/1ps
module tb_usb_packet_buffer;
  import usb_pkt_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [STRB_W-1:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic tok_valid, tok_in, rx_byte_valid, rx_end, tx_byte_req, link_sof, link_suspend;
  logic [6:0] tok_addr;
  logic [3:0] tok_endp;
  logic [7:0] rx_byte, tx_byte;
  logic hs_ack, tx_byte_ready, tx_eop, tx_stuff_err, resume_req, irq;
  logic [7:0] g[$];
  int mismatches = 0, n_tests = 0, cyc = 0, n_ack = 0, n_err = 0, n_res = 0;
  always #2 ref_clk = ~ref_clk;
  usb_packet_buffer #(.SOF_WAIT_CYC(50)) u_usb_packet_buffer (.ref_clk, .rst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tok_valid, .tok_in, .tok_addr, .tok_endp,
    .rx_byte_valid, .rx_byte, .rx_end, .hs_ack, .tx_byte_req, .tx_byte, .tx_byte_ready,
    .tx_eop, .tx_stuff_err, .link_sof, .link_suspend, .resume_req, .irq);
  usb_host_model u_host (.ref_clk, .tok_valid, .tok_in, .tok_addr, .tok_endp,
    .rx_byte_valid, .rx_byte, .rx_end, .tx_byte_req, .link_sof, .link_suspend);
  task end_sim;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Pulse counters and hang limit
  always @(negedge ref_clk)
  begin
    cyc++;
    if (hs_ack === 1'b1) n_ack++;
    if (tx_stuff_err === 1'b1) n_err++;
    if (resume_req === 1'b1) n_res++;
    if (cyc == 30000)
    begin
      mismatches++;
      end_sim;
    end
  end
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic ha, hw, hb;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 0;
    while (!hb)
    begin
      #1;
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge ref_clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    chk("bresp", r, er);
  endtask
  task rd(input logic [11:0] a, input logic [1:0] er = RESP_OKAY);
    logic ha, hr;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 0;
    while (!hr)
    begin
      #1;
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    chk("rresp", r, er);
  endtask
  task st(input logic [31:0] m, input logic [31:0] e);
    rd(REG_STATUS);
    chk("status", v & m, e);
  endtask
  // Payload plus CRC16, low byte first
  task mk(input logic [7:0] p[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (p[i])
    begin
      c = c ^ {8'h00, p[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    g = p;
    g.push_back(~c[7:0]);
    g.push_back(~c[15:8]);
  endtask
  task send(input logic [6:0] a, input logic [3:0] e, input int gap);
    u_host.token(1'b0, a, e);
    u_host.packet(g, gap);
    repeat (4) @(posedge ref_clk);
  endtask
  task t_out;
    int a0;
    wr(REG_DADDR, 32'h65);
    wr(REG_RXCFG, 32'h0001_8010);
    mk('{8'h3C, 8'hA5, 8'h0F});
    a0 = n_ack;
    send(7'h65, 4'hF, 3);
    chk("ack", n_ack - a0, 1);
    rd(REG_RXSTAT);
    chk("rxstat", v, 32'h001F_0005);
    rd(12'h840);
    chk("first", v, 32'h3C);
    rd(12'h84C);
    chk("crc lo", v, g[3]);
    rd(12'h850);
    chk("crc hi", v, g[4]);
    g[4] = ~g[4];
    send(7'h65, 4'hF, 3);
    chk("bad crc", n_ack - a0, 1);
    st(32'h20, 32'h20);
    rd(12'h850);
    chk("raw hi", v, g[4]);
    g[4] = ~g[4];
    wr(12'h848, 32'hEE);
    wr(REG_RXCFG, 32'h0001_0010);
    send(7'h65, 4'hF, 3);
    chk("cap ack", n_ack - a0, 2);
    rd(REG_RXSTAT);
    chk("cap", v, 32'h001F_0002);
    rd(12'h848);
    chk("cap mem", v, 32'hEE);
    $display("test out done");
  endtask
  task t_addr;
    int a0;
    g.delete();
    mk(g);
    a0 = n_ack;
    for (int a = 0; a < 128; a++)
    begin
      wr(REG_DADDR, a);
      send(7'(a), 4'hF, 3);
    end
    send(7'h00, 4'hF, 3);
    chk("ep15", n_ack - a0, 128);
    $display("test addr done");
  endtask
  task t_ovr;
    int a0;
    wr(REG_RXCFG, 32'h0001_8010);
    wr(REG_STATUS, 32'h3F);
    mk('{8'h01, 8'h02, 8'h03, 8'h04});
    a0 = n_ack;
    fork
      send(7'h7F, 4'h1, 1);
      begin
        repeat (3) @(posedge ref_clk);
        rd(12'h840);
      end
    join
    chk("no ack", n_ack - a0, 0);
    st(1, 1);
    chk("irq", irq, 1'b1);
    repeat (20) @(posedge ref_clk);
    st(1, 1);
    wr(REG_STATUS, 1);
    st(1, 0);
    send(7'h7F, 4'h1, 3);
    chk("retry", n_ack - a0, 1);
    $display("test overrun done");
  endtask
  task rdy(input logic eop);
    @(negedge ref_clk);
    while ((eop ? tx_eop : tx_byte_ready) !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask
  task t_in;
    int e0;
    for (int i = 0; i < 4; i++) wr(12'h800 + 12'(4 * i), 32'h11 * (i + 1));
    wr(REG_TXCFG, 32'h0004_0000);
    wr(REG_STATUS, 32'h3F);
    e0 = n_err;
    u_host.token(1'b1, 7'h7F, 4'h2);
    rdy(1'b0);
    u_host.req(2);
    repeat (3) @(posedge ref_clk);
    chk("stuff", n_err - e0, 1);
    st(1, 1);
    wr(REG_STATUS, 32'h3F);
    u_host.token(1'b1, 7'h7F, 4'h2);
    for (int i = 0; i < 4; i++)
    begin
      rdy(1'b0);
      chk("tx byte", tx_byte, 32'h11 * (i + 1));
      u_host.req(1);
    end
    rdy(1'b1);
    u_host.req(1);
    repeat (3) @(posedge ref_clk);
    st(32'h9, 32'h8);
    chk("no stuff", n_err - e0, 1);
    $display("test in done");
  endtask
  task t_suspend_interrupt;
    int r0;
    wr(REG_STATUS, 32'h3F);
    r0 = n_res;
    wr(REG_CTRL, 1);
    repeat (40) @(posedge ref_clk);
    u_host.suspend_interrupt;
    st(2, 0);
    chk("resume", n_res - r0, 1);
    repeat (20) @(posedge ref_clk);
    st(32'h10, 32'h10);
    wr(REG_MASK, 32'h12);
    u_host.suspend_interrupt;
    st(2, 2);
    chk("masked", irq, 1'b0);
    wr(REG_MASK, 0);
    chk("unmasked", irq, 1'b1);
    wr(REG_STATUS, 32'h3F);
    wr(REG_CTRL, 1);
    repeat (5) @(posedge ref_clk);
    u_host.sof;
    repeat (60) @(posedge ref_clk);
    u_host.suspend_interrupt;
    st(32'h12, 2);
    $display("test suspend done");
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(REG_STATUS);
    chk("status rst", v, 0);
    rd(REG_MASK);
    chk("mask rst", v, 0);
    wr(12'h020, 1, RESP_SLVERR);
    rd(12'h020, RESP_SLVERR);
    chk("unmapped", v, 0);
    $display("test regs done");
    t_out;
    t_addr;
    t_ovr;
    t_in;
    t_suspend_interrupt;
    end_sim;
  end
endmodule
